// ==== hdl/tcc_defines.vh ====
// Register map, field positions, codes and timing counts for the timer channel
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH
// Register byte offsets
`define TCC_CTRL_OFF    12'h000
`define TCC_SMODE_OFF   12'h004
`define TCC_STATUS_OFF  12'h008
`define TCC_ENABLE_OFF  12'h00c
`define TCC_EVGEN_OFF   12'h010
`define TCC_CHCFG1_OFF  12'h014
`define TCC_CHCFG2_OFF  12'h018
`define TCC_CNT_OFF     12'h01c
`define TCC_RELOAD_OFF  12'h020
`define TCC_CCV1_OFF    12'h024
`define TCC_CCV2_OFF    12'h028
// Field positions
`define TCC_CTRL_RUN    0
`define TCC_SM_LSB      0
`define TCC_TS_LSB      4
`define TCC_EVF_LSB     1
`define TCC_OVF_LSB     9
`define TCC_IRQE_LSB    1
`define TCC_DMAE_LSB    9
`define TCC_EG_UPD      0
`define TCC_EG_CH_LSB   1
`define TCC_CF_DIR_LSB  0
`define TCC_CF_PSC_LSB  4
`define TCC_CF_FLT_LSB  8
`define TCC_CF_MODE_LSB 12
`define TCC_CF_POL      16
`define TCC_CF_EN       17
`define TCC_CF_PRE      18
// Codes
`define TCC_DIR_OUT     2'h0
`define TCC_DIR_OWN     2'h1
`define TCC_DIR_OTHER   2'h2
`define TCC_MODE_HOLD   3'h0
`define TCC_MODE_SET    3'h1
`define TCC_MODE_CLR    3'h2
`define TCC_MODE_TOG    3'h3
`define TCC_MODE_FLOW   3'h4
`define TCC_MODE_FHIGH  3'h5
`define TCC_TS_CH1EDGE  3'h5
`define TCC_TS_CH2EDGE  3'h6
`define TCC_SMS_RESET   3'h4
// Reset values
`define TCC_RELOAD_RST  16'hffff
`define TCC_CFG_RST     19'h00000
// Filter sample clock: period in ns, kernel period in ns, derived divider
`define TCC_DTS_NS      8
`define TCC_PCLK_NS     8
`define TCC_DTS_DIV     ((`TCC_DTS_NS + `TCC_PCLK_NS - 1) / `TCC_PCLK_NS)
`endif

// ==== hdl/tcc_input_stage.v ====
// Input stage: synchroniser and sample-count digital filter for one input
`timescale 1ns/100ps
module tcc_input_stage (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Raw pin and sample tick
  input  wire       pin_in,
  input  wire       sample_tick,
  // Filter setting
  input  wire [3:0] filter_code,
  // Filtered level
  output reg        filtered_input
);
  reg       sync1_reg;    // First synchroniser stage
  reg       sync2_reg;    // Second synchroniser stage
  reg [4:0] run_reg;      // Samples seen at the new level

  // Required run length for a filter code, zero means no filter
  function [5:0] filt_len;
    input [3:0] code;
    begin
      filt_len = {1'b0, code, 1'b0} + 6'h02;
    end
  endfunction

  // Two-flop synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Filter accepts a level after enough equal samples
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg        <= 5'h00;
      filtered_input <= 1'b0;
    end else if (filter_code == 4'h0) begin
      // Unfiltered: follow the synchronised level
      run_reg        <= 5'h00;
      filtered_input <= sync2_reg;
    end else if (sample_tick) begin
      if (sync2_reg == filtered_input) begin
        // Level unchanged, restart the run
        run_reg <= 5'h00;
      end else if ({1'b0, run_reg} + 6'h01 >= filt_len(filter_code)) begin
        // Enough consecutive samples, accept level
        run_reg        <= 5'h00;
        filtered_input <= sync2_reg; // [RULE11]
      end else begin
        run_reg <= run_reg + 5'h01;
      end
    end
  end
endmodule

// ==== hdl/tcc_timer.v ====
// Two-channel capture/compare timer core with APB register access
//
// Summary of operation
// [RULE1] Software accesses reach only the preload value
// [RULE2] Capture latches counter to shadow, then preload; here shadow and preload both take the counter in the same cycle
// [RULE3] Compare uses shadow copied from preload
// [RULE4] Sample, filter, edge detect, prescale before capture
// [RULE5] Capture stores counter on valid capture event
// [RULE6] Capture sets event flag, irq, dma requests
// [RULE7] Capture with flag set raises overcapture
// [RULE8] Event flag cleared by zero write or read
// [RULE9] Overcapture cleared only by zero write
// [RULE10] Nonzero direction makes input, value read-only
// [RULE11] Filter code 0011 needs eight equal samples
// [RULE12] Polarity zero selects rising edges
// [RULE13] Prescaler code 00 captures every transition
// [RULE14] Capture only while channel enable set
// [RULE15] Event generate bit fakes a capture event
// [RULE16] Two captures share one input, opposite edges
// [RULE17] Direction 10 routes other channel input
// [RULE18] Trigger 101, slave 100 resets counter
// [RULE19] Only channels 1 and 2 feed trigger
// [RULE20] Mode 101 forces reference high, 100 low
// [RULE21] Polarity applied only at output end
// [RULE22] Forced output still compares and flags
// [RULE23] Update event loads preloads into shadows
// [RULE24] Value registers are 16 bits wide
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "tcc_defines.vh"
module tcc_timer (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Channel pins
  input  wire [1:0]  timer_input,
  output reg  [1:0]  channel_output,
  // Requests
  output reg         irq,
  output reg  [1:0]  dma_req
);
  reg        run_reg;          // Counter enable
  reg [2:0]  slave_mode_reg;   // slave_mode_select
  reg [2:0]  trig_sel_reg;     // trigger_select
  reg [15:0] cnt_reg;          // Running counter
  reg [15:0] reload_reg;       // Reload value
  reg [1:0]  irq_en_reg;       // channel_irq_enable
  reg [1:0]  dma_en_reg;       // channel_dma_enable
  reg [3:0]  tick_cnt_reg;     // Sample clock divider
  reg        tick_reg;         // filter_sample_clock tick
  reg        upd_gen_reg;      // Software update request
  reg [1:0]  ch_gen_reg;       // channel_event_generate pulses

  wire [37:0] cfg_all;         // Both channel configurations
  wire [1:0]  filtered_input;  // Per input filtered levels
  wire [1:0]  edge_detected;   // Per channel edge pulses
  wire [1:0]  flag_all;        // channel_event_flag per channel
  wire [1:0]  ovf_all;         // overcapture_flag per channel
  wire [31:0] pre_all;         // Preload values
  wire [1:0]  set_all;         // Flag set pulses
  wire [1:0]  ref_all;         // compare_reference per channel

  // Transfer phases
  wire setup_ph = psel & ~penable;
  wire wr_acc   = psel & penable & pready & pwrite;
  wire rd_acc   = psel & penable & pready & ~pwrite;

  // Input direction test used by several paths
  function is_input;
    input [1:0] dir;
    begin
      is_input = (dir != `TCC_DIR_OUT); // [RULE10]
    end
  endfunction

  // Address hit test
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Trigger from the selected channel edge, only channels 1 and 2
  wire trig_pulse = (trig_sel_reg == `TCC_TS_CH1EDGE) ? edge_detected[0] :
                    (trig_sel_reg == `TCC_TS_CH2EDGE) ? edge_detected[1] :
                    1'b0; // [RULE18] [RULE19]
  wire slave_rst  = (slave_mode_reg == `TCC_SMS_RESET) & trig_pulse;
  wire cnt_wrap   = run_reg & (cnt_reg == reload_reg);
  wire upd_event  = cnt_wrap | upd_gen_reg;

  // Sample clock divider
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 4'h0;
      tick_reg     <= 1'b0;
    end else if ({28'h0, tick_cnt_reg} >= (`TCC_DTS_DIV - 1)) begin
      tick_cnt_reg <= 4'h0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
      tick_reg     <= 1'b0;
    end
  end

  // Counter with reload and slave reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
    end else if (slave_rst) begin
      // Reset mode clears on trigger
      cnt_reg <= 16'h0000; // [RULE18]
    end else if (wr_acc && hit(paddr, `TCC_CNT_OFF)) begin
      cnt_reg <= pwdata[15:0];
    end else if (upd_gen_reg || cnt_wrap) begin
      cnt_reg <= 16'h0000;
    end else if (run_reg) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Global control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg        <= 1'b0;
      slave_mode_reg <= 3'h0;
      trig_sel_reg   <= 3'h0;
      reload_reg     <= `TCC_RELOAD_RST;
      irq_en_reg     <= 2'h0;
      dma_en_reg     <= 2'h0;
      upd_gen_reg    <= 1'b0;
      ch_gen_reg     <= 2'h0;
    end else begin
      // Generate bits are one-cycle pulses
      upd_gen_reg <= 1'b0;
      ch_gen_reg  <= 2'h0;
      if (wr_acc) begin
        if (hit(paddr, `TCC_CTRL_OFF)) begin
          run_reg <= pwdata[`TCC_CTRL_RUN];
        end else if (hit(paddr, `TCC_SMODE_OFF)) begin
          slave_mode_reg <= pwdata[`TCC_SM_LSB +: 3];
          trig_sel_reg   <= pwdata[`TCC_TS_LSB +: 3];
        end else if (hit(paddr, `TCC_ENABLE_OFF)) begin
          irq_en_reg <= pwdata[`TCC_IRQE_LSB +: 2];
          dma_en_reg <= pwdata[`TCC_DMAE_LSB +: 2];
        end else if (hit(paddr, `TCC_EVGEN_OFF)) begin
          upd_gen_reg <= pwdata[`TCC_EG_UPD];
          ch_gen_reg  <= pwdata[`TCC_EG_CH_LSB +: 2]; // [RULE15]
        end else if (hit(paddr, `TCC_RELOAD_OFF)) begin
          reload_reg <= pwdata[15:0];
        end
      end
    end
  end

  // Per channel logic
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      reg  [18:0] cfg_reg;     // Channel configuration
      reg  [15:0] pre_reg;     // Preload value, software view
      reg  [15:0] shadow_reg;  // Shadow value
      reg         flag_reg;    // channel_event_flag
      reg         ovf_reg;     // overcapture_flag
      reg         ref_reg;     // compare_reference
      reg         sel_d_reg;   // Previous selected level
      reg  [2:0]  psc_reg;     // Prescaler event count
      wire [1:0]  dir  = cfg_reg[`TCC_CF_DIR_LSB +: 2];
      wire [1:0]  psc  = cfg_reg[`TCC_CF_PSC_LSB +: 2];
      wire [2:0]  mode = cfg_reg[`TCC_CF_MODE_LSB +: 3];
      wire        pol  = cfg_reg[`TCC_CF_POL];
      wire        en   = cfg_reg[`TCC_CF_EN];
      wire        pre  = cfg_reg[`TCC_CF_PRE];
      wire [11:0] cfg_off = i ? `TCC_CHCFG2_OFF : `TCC_CHCFG1_OFF;
      wire [11:0] ccv_off = i ? `TCC_CCV2_OFF : `TCC_CCV1_OFF;
      // Own input or the other channel input
      wire sel_lvl = (dir == `TCC_DIR_OWN)   ? filtered_input[i] :
                     (dir == `TCC_DIR_OTHER) ? filtered_input[1-i] :
                     1'b0; // [RULE17] [RULE16]
      // Polarity 0 rising, 1 falling
      wire edge_p = pol ? (sel_d_reg & ~sel_lvl)
                        : (~sel_d_reg & sel_lvl); // [RULE12] [RULE4]
      // Prescaler: 2^code valid transitions per capture
      wire [2:0] psc_max = (3'h1 << psc) - 3'h1;
      wire psc_hit = edge_p & (psc_reg == psc_max); // [RULE13]
      wire capture = is_input(dir) & en & psc_hit; // [RULE14] [RULE5]
      wire match   = ~is_input(dir) & (cnt_reg == shadow_reg); // [RULE3]
      wire set_ev  = capture | match | ch_gen_reg[i]; // [RULE22] [RULE15]
      wire ccv_wr  = wr_acc & hit(paddr, ccv_off) & ~is_input(dir);
      wire ccv_rd  = rd_acc & hit(paddr, ccv_off) & is_input(dir);
      wire st_wr   = wr_acc & hit(paddr, `TCC_STATUS_OFF);

      assign edge_detected[i] = edge_p;
      assign cfg_all[19*i +: 19] = cfg_reg;
      assign pre_all[16*i +: 16] = pre_reg;
      assign flag_all[i] = flag_reg;
      assign ovf_all[i]  = ovf_reg;
      assign set_all[i]  = set_ev;
      assign ref_all[i]  = ref_reg;

      // Edge detector history and prescaler count
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_d_reg <= 1'b0;
          psc_reg   <= 3'h0;
        end else begin
          sel_d_reg <= sel_lvl;
          if (!is_input(dir) || !en) begin
            psc_reg <= 3'h0;
          end else if (psc_hit) begin
            psc_reg <= 3'h0;
          end else if (edge_p) begin
            psc_reg <= psc_reg + 3'h1; // [RULE4]
          end
        end
      end

      // Configuration, preload and shadow values
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_reg    <= `TCC_CFG_RST;
          pre_reg    <= 16'h0000;
          shadow_reg <= 16'h0000;
        end else begin
          if (wr_acc && hit(paddr, cfg_off)) begin
            cfg_reg <= pwdata[18:0];
          end
          if (capture) begin
            // Counter into shadow and preload in the same cycle
            shadow_reg <= cnt_reg; // [RULE2]
            pre_reg    <= cnt_reg; // [RULE2]
          end else begin
            if (ccv_wr) begin
              pre_reg <= pwdata[15:0]; // [RULE1] [RULE24]
            end
            if (!is_input(dir) && (!pre || upd_event)) begin
              shadow_reg <= pre_reg; // [RULE23] [RULE3]
            end
          end
        end
      end

      // Flags: hardware set beats software clear
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_reg <= 1'b0;
          ovf_reg  <= 1'b0;
        end else begin
          if (set_ev) begin
            flag_reg <= 1'b1; // [RULE6]
          end else if (ccv_rd) begin
            flag_reg <= 1'b0; // [RULE8]
          end else if (st_wr && !pwdata[`TCC_EVF_LSB + i]) begin
            flag_reg <= 1'b0; // [RULE8]
          end
          if ((capture || ch_gen_reg[i]) && is_input(dir) && flag_reg) begin
            ovf_reg <= 1'b1; // [RULE7]
          end else if (st_wr && !pwdata[`TCC_OVF_LSB + i]) begin
            ovf_reg <= 1'b0; // [RULE9]
          end
        end
      end

      // Reference waveform, active high
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ref_reg <= 1'b0;
        end else if (mode == `TCC_MODE_FHIGH) begin
          ref_reg <= 1'b1; // [RULE20]
        end else if (mode == `TCC_MODE_FLOW) begin
          ref_reg <= 1'b0; // [RULE20]
        end else if (match) begin
          case (mode)
            `TCC_MODE_SET: begin
              ref_reg <= 1'b1;
            end
            `TCC_MODE_CLR: begin
              ref_reg <= 1'b0;
            end
            `TCC_MODE_TOG: begin
              ref_reg <= ~ref_reg;
            end
            default: begin
              ref_reg <= ref_reg;
            end
          endcase
        end
      end
    end
  endgenerate

  // One input stage per pin, filter taken from the owning channel
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_in
      tcc_input_stage tcc_input_stage_inst (
        .pclk           (pclk),
        .presetn        (presetn),
        .pin_in         (timer_input[i]),
        .sample_tick    (tick_reg),
        .filter_code    (cfg_all[19*i + `TCC_CF_FLT_LSB +: 4]),
        .filtered_input (filtered_input[i])
      );
    end
  endgenerate

  // Output pins, requests and interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_output <= 2'h0;
      irq            <= 1'b0;
      dma_req        <= 2'h0;
    end else begin
      // Polarity only at the end of the chain, gated by enable
      channel_output[0] <= cfg_all[`TCC_CF_EN] &
                           (ref_all[0] ^ cfg_all[`TCC_CF_POL]); // [RULE21]
      channel_output[1] <= cfg_all[19 + `TCC_CF_EN] &
                           (ref_all[1] ^ cfg_all[19 + `TCC_CF_POL]);
      irq     <= |(flag_all & irq_en_reg); // [RULE6]
      dma_req <= set_all & dma_en_reg; // [RULE6]
    end
  end

  // APB answer: decoded in setup, ready in access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (hit(paddr, `TCC_CTRL_OFF)) begin
        prdata[`TCC_CTRL_RUN] <= run_reg;
      end else if (hit(paddr, `TCC_SMODE_OFF)) begin
        prdata[`TCC_SM_LSB +: 3] <= slave_mode_reg;
        prdata[`TCC_TS_LSB +: 3] <= trig_sel_reg;
      end else if (hit(paddr, `TCC_STATUS_OFF)) begin
        prdata[`TCC_EVF_LSB +: 2] <= flag_all;
        prdata[`TCC_OVF_LSB +: 2] <= ovf_all;
      end else if (hit(paddr, `TCC_ENABLE_OFF)) begin
        prdata[`TCC_IRQE_LSB +: 2] <= irq_en_reg;
        prdata[`TCC_DMAE_LSB +: 2] <= dma_en_reg;
      end else if (hit(paddr, `TCC_EVGEN_OFF)) begin
        prdata <= 32'h00000000;
      end else if (hit(paddr, `TCC_CHCFG1_OFF)) begin
        prdata[18:0] <= cfg_all[18:0];
      end else if (hit(paddr, `TCC_CHCFG2_OFF)) begin
        prdata[18:0] <= cfg_all[37:19];
      end else if (hit(paddr, `TCC_CNT_OFF)) begin
        prdata[15:0] <= cnt_reg;
      end else if (hit(paddr, `TCC_RELOAD_OFF)) begin
        prdata[15:0] <= reload_reg;
      end else if (hit(paddr, `TCC_CCV1_OFF)) begin
        prdata[15:0] <= pre_all[15:0]; // [RULE1]
      end else if (hit(paddr, `TCC_CCV2_OFF)) begin
        prdata[15:0] <= pre_all[31:16]; // [RULE1]
      end else begin
        // Unmapped address
        pslverr <= 1'b1;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// ==== dv/tcc_timer_assertions.sv ====
// Concurrent checks on the timer block's bus and request ports
`timescale 1ns/100ps
`include "tcc_defines.vh"
module tcc_timer_assertions (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // Bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Requests
  input wire        irq,
  input wire [1:0]  dma_req
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Read beat of an access cycle
  wire rd_beat = psel && penable && pready && !pwrite;
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_unmapped_a: assert property (
    pready && paddr > `TCC_CCV2_OFF |-> pslverr)
    else $error("unmapped access not refused");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  evgen_zero_a: assert property (
    rd_beat && paddr == `TCC_EVGEN_OFF |-> prdata == 32'h0)
    else $error("event register reads nonzero");
  value_width_a: assert property (
    rd_beat && (paddr == `TCC_CCV1_OFF || paddr == `TCC_CCV2_OFF ||
    paddr == `TCC_CNT_OFF) |-> prdata[31:16] == 16'h0)
    else $error("value wider than counter");
  dma_pulse_a: assert property (
    dma_req != 2'h0 |=> (dma_req & $past(dma_req)) == 2'h0)
    else $error("dma request longer than a pulse");
  // Main scenarios reached
  cover property (rd_beat && paddr == `TCC_CCV1_OFF);
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property (dma_req[1]);
endmodule

// ==== dv/tcc_pin_model.sv ====
// Pin-side model driving the two timer input pins
`timescale 1ns/100ps
module tcc_pin_model (
  // Clock
  input  wire        pclk,
  // Driven pins
  output logic [1:0] timer_input
);
  // Pins idle low
  initial timer_input = 2'h0;
  // Change one pin just after an edge
  task automatic set_pin(input int ch, input logic v);
    @(posedge pclk);
    timer_input[ch] <= v;
  endtask
  // High pulse of len cycles, then settle past the filter
  task automatic pulse(input int ch, input int len);
    set_pin(ch, 1'b1);
    repeat (len - 1) @(posedge pclk);
    set_pin(ch, 1'b0);
    repeat (16) @(posedge pclk);
  endtask
  // Periodic wave on pin 0, shared by both captures
  task automatic pwm(input int hi, input int lo, input int cnt);
    repeat (cnt) begin
      set_pin(0, 1'b1);
      repeat (hi - 1) @(posedge pclk);
      set_pin(0, 1'b0);
      repeat (lo - 1) @(posedge pclk);
    end
  endtask
endmodule

// ==== dv/tcc_timer_tb.sv ====
// Self-checking bench for the two-channel capture/compare timer
`timescale 1ns/100ps
`include "tcc_defines.vh"
module tcc_timer_tb;
  // Clock, reset and bus master
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  // Design outputs and the timer input pins
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [1:0]  timer_input;
  wire  [1:0]  channel_output;
  wire         irq;
  wire  [1:0]  dma_req;
  // Scoreboard and last answer
  int          fail_count = 0;
  int          checks_done = 0;
  int          dma_seen = 0;
  logic [31:0] rv;
  logic        ev;
  always #4 pclk = ~pclk;
  // Count request pulses
  always @(posedge pclk)
    if (dma_req[0] === 1'b1 || dma_req[1] === 1'b1)
      dma_seen <= dma_seen + 1;
  tcc_timer tcc_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input(timer_input), .channel_output(channel_output),
    .irq(irq), .dma_req(dma_req));
  tcc_pin_model tcc_pin_model_inst (.pclk(pclk),
    .timer_input(timer_input));
  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50)
      fail_count++;
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  // Channel setting word
  function automatic logic [31:0] cfg(input logic [1:0] dir,
    input logic [1:0] psc, input logic [3:0] flt, input logic [2:0] md,
    input logic pol, input logic en);
    cfg = {13'h0, 1'b0, en, pol, 1'b0, md, flt, 2'h0, psc, 2'h0, dir};
  endfunction
  task automatic pls(input int n);
    tcc_pin_model_inst.pulse(0, n);
  endtask
  // Reset values, width, refusal, plain access
  task automatic t_reset;
    rd(`TCC_RELOAD_OFF, 32'hffff);
    rd(`TCC_CCV1_OFF, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, ev}, 32'h1);
    wr(`TCC_CCV1_OFF, 32'hffffabcd);
    rd(`TCC_CCV1_OFF, 32'habcd);
    wr(`TCC_CNT_OFF, 32'h0001ffff);
    rd(`TCC_CNT_OFF, 32'hffff);
    wr(`TCC_CHCFG2_OFF, cfg(2'h1, 2'h0, 4'h0, 3'h0, 1'b0, 1'b0));
  endtask
  // Capture, flags, overcapture and clearing
  task automatic t_capture;
    int d0;
    wr(`TCC_CHCFG1_OFF, cfg(2'h1, 2'h0, 4'h0, 3'h0, 1'b0, 1'b0));
    wr(`TCC_STATUS_OFF, 32'h0);
    wr(`TCC_ENABLE_OFF, 32'h202);
    wr(`TCC_CCV1_OFF, 32'h5555);
    rd(`TCC_CCV1_OFF, 32'habcd);
    pls(4);
    rd(`TCC_STATUS_OFF, 32'h0);
    wr(`TCC_CHCFG1_OFF, cfg(2'h1, 2'h0, 4'h0, 3'h0, 1'b0, 1'b1));
    wr(`TCC_CNT_OFF, 32'h1234);
    d0 = dma_seen;
    pls(4);
    chk({31'h0, irq}, 32'h1);
    chk(dma_seen - d0, 32'h1);
    rd(`TCC_STATUS_OFF, 32'h2);
    rd(`TCC_CCV1_OFF, 32'h1234);
    wr(`TCC_CNT_OFF, 32'h2222);
    pls(4);
    pls(4);
    rd(`TCC_STATUS_OFF, 32'h202);
    rd(`TCC_CCV1_OFF, 32'h2222);
    rd(`TCC_STATUS_OFF, 32'h200);
    pls(4);
    wr(`TCC_STATUS_OFF, 32'h0);
    rd(`TCC_STATUS_OFF, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  // Active edge follows polarity
  task automatic t_polarity;
    for (int p = 0; p < 2; p++) begin
      wr(`TCC_CHCFG1_OFF, cfg(2'h1, 2'h0, 4'h0, 3'h0, p == 1, 1'b1));
      wr(`TCC_CNT_OFF, 32'h100);
      tcc_pin_model_inst.set_pin(0, 1'b1);
      repeat (8) @(posedge pclk);
      wr(`TCC_CNT_OFF, 32'h200);
      tcc_pin_model_inst.set_pin(0, 1'b0);
      repeat (8) @(posedge pclk);
      rd(`TCC_CCV1_OFF, p ? 32'h200 : 32'h100);
    end
  endtask
  // Filter length and capture prescaler
  task automatic t_filter;
    int d0;
    wr(`TCC_CHCFG1_OFF, cfg(2'h1, 2'h0, 4'h3, 3'h0, 1'b0, 1'b1));
    wr(`TCC_STATUS_OFF, 32'h0);
    pls(7);
    rd(`TCC_STATUS_OFF, 32'h0);
    pls(9);
    rd(`TCC_STATUS_OFF, 32'h2);
    wr(`TCC_CHCFG1_OFF, cfg(2'h1, 2'h1, 4'h0, 3'h0, 1'b0, 1'b1));
    d0 = dma_seen;
    repeat (4) pls(3);
    chk(dma_seen - d0, 32'h2);
  endtask
  // Software event on channel two
  task automatic t_evgen;
    int d0;
    wr(`TCC_ENABLE_OFF, 32'h404);
    wr(`TCC_STATUS_OFF, 32'h0);
    d0 = dma_seen;
    wr(`TCC_EVGEN_OFF, 32'h4);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    chk(dma_seen - d0, 32'h1);
    rd(`TCC_STATUS_OFF, 32'h4);
  endtask
  // Period and high time from one input
  task automatic t_pwm;
    logic [31:0] per;
    wr(`TCC_CHCFG1_OFF, cfg(2'h1, 2'h0, 4'h0, 3'h0, 1'b0, 1'b1));
    wr(`TCC_CHCFG2_OFF, cfg(2'h2, 2'h0, 4'h0, 3'h0, 1'b1, 1'b1));
    wr(`TCC_SMODE_OFF, 32'h54);
    wr(`TCC_CTRL_OFF, 32'h1);
    tcc_pin_model_inst.pwm(20, 30, 4);
    apb(1'b0, `TCC_CCV1_OFF, 32'h0);
    per = rv;
    apb(1'b0, `TCC_CCV2_OFF, 32'h0);
    chk(per - rv, 32'd30);
    chk({31'h0, per == 32'd49 || per == 32'd50}, 32'h1);
    wr(`TCC_CTRL_OFF, 32'h0);
    wr(`TCC_SMODE_OFF, 32'h0);
  endtask
  // Forced level seen at the pin
  task automatic fchk(input logic [2:0] md, input logic pol,
                      input logic exp);
    wr(`TCC_CHCFG1_OFF, cfg(2'h0, 2'h0, 4'h0, md, pol, 1'b1));
    repeat (3) @(posedge pclk);
    chk({31'h0, channel_output[0]}, {31'h0, exp});
  endtask
  // Forced output still compares
  task automatic t_force;
    wr(`TCC_ENABLE_OFF, 32'h202);
    fchk(3'h4, 1'b0, 1'b0);
    fchk(3'h5, 1'b1, 1'b0);
    fchk(3'h5, 1'b0, 1'b1);
    wr(`TCC_RELOAD_OFF, 32'h20);
    wr(`TCC_CCV1_OFF, 32'h10);
    wr(`TCC_CNT_OFF, 32'h0);
    wr(`TCC_STATUS_OFF, 32'h0);
    wr(`TCC_CTRL_OFF, 32'h1);
    repeat (40) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, channel_output[0]}, 32'h1);
    apb(1'b0, `TCC_STATUS_OFF, 32'h0);
    chk(rv & 32'h2, 32'h2);
    // Preload on: shadow waits for an update event
    wr(`TCC_ENABLE_OFF, 32'h2);
    wr(`TCC_CTRL_OFF, 32'h0);
    wr(`TCC_CHCFG1_OFF, cfg(2'h0, 2'h0, 4'h0, 3'h5, 1'b0, 1'b1) | 32'h40000);
    wr(`TCC_CCV1_OFF, 32'h18);
    wr(`TCC_CNT_OFF, 32'h18);
    wr(`TCC_STATUS_OFF, 32'h0);
    rd(`TCC_STATUS_OFF, 32'h0);
    wr(`TCC_EVGEN_OFF, 32'h1);
    wr(`TCC_CNT_OFF, 32'h18);
    rd(`TCC_STATUS_OFF, 32'h2);
  endtask
  // Verdict and end of run
  task automatic test_done;
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_capture();
    t_polarity();
    t_filter();
    t_evgen();
    t_pwm();
    t_force();
    test_done();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule
bind tcc_timer tcc_timer_assertions tcc_timer_assertions_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .dma_req(dma_req));
